// File: core_mem_model.sv
module core_mem_model
  import cpu_pkg::*;
#(
  parameter int RESTORE_AGE = 46
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core memory
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic mem_go,
  input wire logic mem_read,
  output logic [WORD_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // thirteen address lines for the 8K option
  logic [WORD_W-1:0] mem [0:8191];
  logic [ADDR_W-1:0] loc_r;
  logic [WORD_W-1:0] sense_r;
  logic [5:0] age_r;
  logic rd_r;
  // select, destructive read, write from working reg
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      age_r <= 6'h3F;
      rd_r <= 1'b0;
      sense_r <= 12'h000;
    end else if (mem_go) begin
      age_r <= 6'h00;
      rd_r <= mem_read;
      loc_r <= mem_addr;
      if (mem_read) begin
        sense_r <= mem[mem_addr];
        mem[mem_addr] <= 12'h000;
      end
    end else if (age_r != 6'h3F) begin
      age_r <= age_r + 6'h01;
      if (age_r == 6'(RESTORE_AGE)) begin
        mem[loc_r] <= mem_wdata;
      end
    end
  end
  // released sense lines show the inverse
  assign mem_rdata = (rd_r && age_r < 6'h2D) ? sense_r : ~sense_r;
endmodule : core_mem_model

// File: cpu_pkg.sv
package cpu_pkg;

  // ****************
  // widths
  // ****************
  localparam int WORD_W = 12;
  localparam int ADDR_W = 13;
  localparam int TS_N = 11;
  localparam int CNT_W = 4;
  localparam int F_W = 4;

  // ****************
  // timing
  // ****************
  localparam int STATE_NS = 424;
  localparam int CLK_PS = 10000;
  localparam int STATE_CYC = (STATE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [5:0] TICK_LAST = 6'(STATE_CYC - 1);

  // ****************
  // time-state positions
  // ****************
  localparam int TF1 = 0;
  localparam int TF2 = 1;
  localparam int TF3 = 2;
  localparam int TF4 = 3;
  localparam int TF5 = 4;
  localparam int TE1 = 5;
  localparam int TE2 = 6;
  localparam int TE3 = 7;
  localparam int TE4 = 8;
  localparam int TE6 = 10;
  localparam logic [TS_N-1:0] TS_IDLE = 11'h000;
  localparam logic [TS_N-1:0] TS_TF1 = 11'h001;
  localparam logic [TS_N-1:0] TS_TF2 = 11'h002;
  localparam logic [TS_N-1:0] TS_TE1 = 11'h020;

  // ****************
  // instruction fields
  // ****************
  localparam int IND_BIT = 11;
  localparam int SECTOR_BIT = 7;
  localparam int F_LSB = 8;
  localparam int LOW_MSB = 6;
  localparam int PC_TOP = 12;

  // ****************
  // op codes and sub-codes
  // ****************
  localparam logic [2:0] OP_NONMR = 3'h0;
  localparam logic [2:0] OP_LDA = 3'h1;
  localparam logic [2:0] OP_STA = 3'h2;
  localparam logic [2:0] OP_JMP = 3'h3;
  localparam logic [2:0] OP_ADD = 3'h4;
  localparam logic [2:0] OP_ANA = 3'h5;
  localparam logic [2:0] OP_IRS = 3'h6;
  localparam logic [2:0] OP_JST = 3'h7;
  localparam logic [2:0] GRP_GEN = 3'h0;
  localparam logic [2:0] GRP_SHIFT = 3'h1;
  localparam logic [2:0] GRP_SKIP = 3'h2;
  localparam logic [5:0] GEN_HLT = 6'h00;
  localparam logic [5:0] GEN_OCA = 6'h03;
  localparam logic [5:0] GEN_TCA = 6'h05;
  localparam logic [5:0] GEN_ITS = 6'h14;
  localparam logic [5:0] GEN_TOA = 6'h18;
  localparam logic [5:0] GEN_ITR = 6'h22;
  localparam logic [5:0] GEN_CRA = 6'h30;
  localparam logic [5:0] SKIP_SOV = 6'h04;
  localparam logic [1:0] SH_LGR = 2'h0;
  localparam logic [1:0] SH_ARS = 2'h1;
  localparam logic [1:0] SH_RAR = 2'h2;
  localparam logic [CNT_W-1:0] ARITH_STEPS = 4'hC;

  // ****************
  // reset values
  // ****************
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_PC = 2'b01,
    SRC_ACC = 2'b11,
    SRC_WR = 2'b10
  } bus_src_t;

  typedef enum logic [3:0] {
    SER_NONE, SER_ADD, SER_AND, SER_OCA, SER_TCA, SER_IRS, SER_LGR, SER_ARS, SER_RAR
  } ser_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] wr;
    logic [F_W-1:0] func;
    logic [CNT_W-1:0] count;
    logic carry;
    logic bank;
    logic [1:0] hold;
  } cpu_view_t;

endpackage : cpu_pkg

// File: serial_cpu_datapath_fetch.sv
// Contract
// - eleven one-hot time states: five fetch, then six execute
// - thirteen-line transfer bus joins all registers, gated by bus control; carry, bank bit and holding reg are not on the bus
// - acc and working reg drive and load; count, func, addr load; pc drives
// - fetch one: pc onto bus, bus low and high bits into address reg
// - address reg selects word; reads load working reg, which is written back
// - address reg thirteen bits, loads from bus, feeds memory and pc
// - pc increments after copy; jump and jump-store load it from address reg
// - working reg loads in parallel and shifts through the adder
// - accumulator shifts into adder and receives results; bus exchange
// - one-bit adder: complement, rotate, add, and, increment working reg
// - carry links serial steps; set before increments, cleared before others
// - carry keeps final add overflow for skip and transfer tests
// - shift count loaded complemented from bus, counts down, ends at zero
// - counter sequences arithmetic ops by detecting its count
// - function reg loads instruction bits 9 to 12 in fetch four
// - bank bit loaded with pc top bit on indirect jump and jump-store
// - two-bit holding reg saves pc top and bank, restores on return
// - fetch and execute alternate until stop control or halt
// - fetch is five 424 ns states, begun by start or instruction end
// - fetch two increments pc, except in an indirect cycle, and starts memory cycle
// - fetch three clears working reg, loads read word, writes it back
// - fetch five loads low address; bit 8 picks current or primary sector
// - fetch five bit 12 chooses execute or one indirect cycle
// - execute ends at state one, three or six; arithmetic holds state four
module serial_cpu_datapath_fetch
  import cpu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // panel
  input wire logic start,
  input wire logic stop,
  // core memory
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_wdata,
  output logic mem_go,
  output logic mem_read,
  // status
  output logic [TS_N-1:0] time_state,
  output logic running,
  output cpu_view_t view
);

  // ****************
  // registers
  // ****************
  logic [5:0] tick_cnt_r;
  logic [TS_N-1:0] ts_r;
  logic run_r, ind_r, ind_seen_r;
  logic [ADDR_W-1:0] pc_r, y_r;
  logic [WORD_W-1:0] w_r, acc_r;
  logic [F_W-1:0] f_r;
  logic [CNT_W-1:0] c_r;
  ser_mode_t mode_r;
  logic carry_r, bank_r;
  logic [1:0] z_r;
  logic mem_go_r, mem_read_r;

  // ****************
  // control decode
  // ****************
  logic tick, hold, step, end_i, ind_go;
  logic [ADDR_W-1:0] bus;
  bus_src_t src;
  logic y_ld_bus, y_ld_sec, w_clr, w_ld_mem, w_ld_bus, acc_ld_bus;
  logic pc_inc, pc_ld_y, f_ld, c_ld_bus, c_ld_arith, go, rd, halt;
  logic carry_set, carry_clr, bank_ld, z_save, z_restore, acc_clr, acc_toa;
  ser_mode_t mode_nxt;
  logic [2:0] op, grp;
  logic [5:0] sub;

  assign tick = (tick_cnt_r == TICK_LAST);
  assign op = f_r[2:0];
  assign grp = w_r[8:6];
  assign sub = w_r[5:0];
  assign step = (mode_r != SER_NONE) && (c_r != '0);
  assign hold = ts_r[TE4] && step;
  assign ind_go = ts_r[TF5] && !ind_r && w_r[IND_BIT] && (f_r[2:0] != OP_NONMR);

  always_comb begin
    src = SRC_NONE;
    {y_ld_bus, y_ld_sec, w_clr, w_ld_mem, w_ld_bus, acc_ld_bus} = '0;
    {pc_inc, pc_ld_y, f_ld, c_ld_bus, c_ld_arith, go, rd, halt, end_i} = '0;
    {carry_set, carry_clr, bank_ld, z_save, z_restore, acc_clr, acc_toa} = '0;
    mode_nxt = SER_NONE;
    if (ts_r[TF1]) begin
      src = SRC_PC;
      y_ld_bus = 1'b1;
    end
    if (ts_r[TF2]) begin
      pc_inc = !ind_r;
      go = 1'b1;
      rd = 1'b1;
    end
    if (ts_r[TF3]) begin
      w_ld_mem = 1'b1;
    end
    if (ts_r[TF4]) begin
      src = SRC_WR;
      f_ld = !ind_r;
    end
    if (ts_r[TF5]) begin
      src = SRC_WR;
      y_ld_sec = !ind_r;
      y_ld_bus = ind_r;
    end
    if (ts_r[TE1]) begin
      unique case (op)
        OP_LDA, OP_ADD, OP_ANA, OP_IRS: begin
          go = 1'b1;
          rd = 1'b1;
        end
        OP_STA: begin
          src = SRC_ACC;
          w_ld_bus = 1'b1;
          go = 1'b1;
        end
        OP_JMP: begin
          pc_ld_y = 1'b1;
          bank_ld = ind_seen_r;
          end_i = 1'b1;
        end
        OP_JST: begin
          src = SRC_PC;
          w_clr = 1'b1;
          w_ld_bus = 1'b1;
          go = 1'b1;
        end
        OP_NONMR: begin
          end_i = 1'b1;
          if (!f_r[3] && grp == GRP_GEN) begin
            halt = (sub == GEN_HLT);
            acc_clr = (sub == GEN_CRA);
            acc_toa = (sub == GEN_TOA);
            z_save = (sub == GEN_ITS);
            z_restore = (sub == GEN_ITR);
            end_i = (sub != GEN_OCA) && (sub != GEN_TCA);
          end else if (!f_r[3] && grp == GRP_SHIFT) begin
            src = SRC_WR;
            c_ld_bus = 1'b1;
            carry_clr = 1'b1;
            mode_nxt = (w_r[5:4] == SH_ARS) ? SER_ARS : (w_r[5:4] == SH_RAR) ? SER_RAR : SER_LGR;
            end_i = 1'b0;
          end else if (!f_r[3] && grp == GRP_SKIP) begin
            pc_inc = (sub == SKIP_SOV) && carry_r;
          end
        end
      endcase
    end
    if (ts_r[TE2]) begin
      w_ld_mem = (op == OP_LDA) || (op == OP_ADD) || (op == OP_ANA) || (op == OP_IRS);
    end
    if (ts_r[TE3]) begin
      unique case (op)
        OP_LDA: begin
          src = SRC_WR;
          acc_ld_bus = 1'b1;
          end_i = 1'b1;
        end
        OP_STA: end_i = 1'b1;
        OP_JST: begin
          pc_ld_y = 1'b1;
          pc_inc = 1'b1;
          bank_ld = ind_seen_r;
          end_i = 1'b1;
        end
        OP_ADD, OP_ANA, OP_IRS: begin
          c_ld_arith = 1'b1;
          carry_set = (op == OP_IRS);
          carry_clr = (op != OP_IRS);
          mode_nxt = (op == OP_ADD) ? SER_ADD : (op == OP_ANA) ? SER_AND : SER_IRS;
        end
        default: begin
          if (grp == GRP_GEN && !f_r[3]) begin
            c_ld_arith = 1'b1;
            carry_set = (sub == GEN_TCA);
            carry_clr = (sub == GEN_OCA);
            mode_nxt = (sub == GEN_TCA) ? SER_TCA : SER_OCA;
          end
        end
      endcase
    end
    if (ts_r[TE4] && op == OP_IRS) begin
      go = 1'b1;
    end
    if (ts_r[TE6]) begin
      pc_inc = (op == OP_IRS) && (w_r == WORD_RST);
      end_i = 1'b1;
    end
  end

  always_comb begin
    unique case (src)
      SRC_PC: bus = pc_r;
      SRC_ACC: bus = {1'b0, acc_r};
      SRC_WR: bus = {1'b0, w_r};
      default: bus = ADDR_RST;
    endcase
  end

  // ****************
  // serial adder
  // ****************
  logic a_b, w_b, s_b, c_b;
  always_comb begin
    a_b = acc_r[0];
    w_b = w_r[0];
    s_b = a_b;
    c_b = carry_r;
    unique case (mode_r)
      SER_ADD: begin
        s_b = a_b ^ w_b ^ carry_r;
        c_b = (a_b & w_b) | (a_b & carry_r) | (w_b & carry_r);
      end
      SER_AND: s_b = a_b & w_b;
      SER_OCA: s_b = ~a_b;
      SER_TCA: begin
        s_b = ~a_b ^ carry_r;
        c_b = ~a_b & carry_r;
      end
      SER_IRS: begin
        s_b = w_b ^ carry_r;
        c_b = w_b & carry_r;
      end
      SER_LGR: s_b = 1'b0;
      SER_ARS: s_b = acc_r[WORD_W-1];
      default: s_b = a_b;
    endcase
  end

  // ****************
  // time-state generator
  // ****************
  // state period prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
    end else if (ts_r == TS_IDLE || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_r <= TS_IDLE;
    end else if (ts_r == TS_IDLE) begin
      if (start) ts_r <= TS_TF1;
    end else if (tick && !hold) begin
      if (end_i) ts_r <= (run_r && !halt && !stop) ? TS_TF1 : TS_IDLE;
      else if (ts_r[TF5]) ts_r <= ind_go ? TS_TF2 : TS_TE1;
      else ts_r <= {ts_r[TS_N-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
    end else if (ts_r == TS_IDLE) begin
      run_r <= start;
    end else if (stop || (tick && halt)) begin
      run_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ind_r <= 1'b0;
      ind_seen_r <= 1'b0;
    end else if (tick) begin
      if (ts_r[TF5]) ind_r <= ind_go;
      if (ts_r[TF5] && ind_go) ind_seen_r <= 1'b1;
      else if (ts_r[TF1]) ind_seen_r <= 1'b0;
    end
  end

  // ****************
  // registers on the bus
  // ****************
  // address register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      y_r <= ADDR_RST;
    end else if (tick && y_ld_bus) begin
      y_r <= ind_r ? {bank_r, bus[WORD_W-1:0]} : bus;
    end else if (tick && y_ld_sec) begin
      y_r[LOW_MSB:0] <= bus[LOW_MSB:0];
      if (!w_r[SECTOR_BIT]) y_r[WORD_W-1:LOW_MSB+1] <= '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= ADDR_RST;
    end else if (tick && pc_ld_y) begin
      pc_r <= pc_inc ? y_r + 13'h0001 : y_r;
    end else if (tick && z_restore) begin
      pc_r[PC_TOP] <= z_r[1];
    end else if (tick && pc_inc) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_r <= WORD_RST;
    end else if (ts_r[TF3] && tick_cnt_r == '0) begin
      w_r <= WORD_RST;
    end else if (tick && w_ld_mem) begin
      w_r <= mem_rdata;
    end else if (tick && (w_ld_bus || w_clr)) begin
      w_r <= w_ld_bus ? bus[WORD_W-1:0] : WORD_RST;
    end else if (step && mode_r == SER_IRS) begin
      w_r <= {s_b, w_r[WORD_W-1:1]};
    end else if (step && (mode_r == SER_ADD || mode_r == SER_AND)) begin
      w_r <= {w_b, w_r[WORD_W-1:1]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= WORD_RST;
    end else if (tick && acc_ld_bus) begin
      acc_r <= bus[WORD_W-1:0];
    end else if (tick && acc_clr) begin
      acc_r <= WORD_RST;
    end else if (tick && acc_toa) begin
      acc_r <= {11'h000, carry_r};
    end else if (step && mode_r != SER_IRS) begin
      acc_r <= {s_b, acc_r[WORD_W-1:1]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_r <= '0;
    end else if (tick && f_ld) begin
      f_r <= bus[WORD_W-1:F_LSB];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_r <= '0;
      mode_r <= SER_NONE;
    end else if (tick && (c_ld_bus || c_ld_arith)) begin
      c_r <= c_ld_bus ? ~bus[CNT_W-1:0] : ARITH_STEPS;
      mode_r <= mode_nxt;
    end else if (step) begin
      c_r <= c_r - 4'h1;
    end else if (tick && end_i) begin
      mode_r <= SER_NONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_r <= 1'b0;
    end else if (tick && carry_set) begin
      carry_r <= 1'b1;
    end else if (tick && carry_clr) begin
      carry_r <= 1'b0;
    end else if (step) begin
      carry_r <= c_b;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_r <= 1'b0;
      z_r <= 2'h0;
    end else if (tick) begin
      if (bank_ld) bank_r <= pc_r[PC_TOP];
      else if (z_restore) bank_r <= z_r[0];
      if (z_save) z_r <= {pc_r[PC_TOP], bank_r};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_go_r <= 1'b0;
      mem_read_r <= 1'b0;
    end else begin
      mem_go_r <= tick && go;
      if (tick && go) mem_read_r <= rd;
    end
  end

  assign mem_addr = y_r;
  assign mem_wdata = w_r;
  assign mem_go = mem_go_r;
  assign mem_read = mem_read_r;
  assign time_state = ts_r;
  assign running = run_r;
  assign view = '{pc: pc_r, addr: y_r, acc: acc_r, wr: w_r, func: f_r, count: c_r,
                  carry: carry_r, bank: bank_r, hold: z_r};

endmodule : serial_cpu_datapath_fetch

// File: serial_cpu_datapath_fetch_chk.sv
module serial_cpu_datapath_fetch_chk
  import cpu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // panel
  input wire logic start,
  input wire logic stop,
  // core memory
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic mem_go,
  input wire logic mem_read,
  // status
  input wire logic [TS_N-1:0] time_state,
  input wire logic running,
  input wire cpu_view_t view
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [TS_N-1:0] prev_r;
  logic [5:0] dwell_r;
  logic norm_r;
  // ****************
  // dwell and fetch kind
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= TS_IDLE;
      dwell_r <= 6'h00;
    end else begin
      prev_r <= time_state;
      dwell_r <= (time_state != prev_r) ? 6'h00 : dwell_r + 6'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      norm_r <= 1'b0;
    end else if (time_state[TF1]) begin
      norm_r <= 1'b1;
    end else if (time_state[TF2] && prev_r[TF5]) begin
      norm_r <= 1'b0;
    end
  end
  // ****************
  // assertions
  // ****************
  AST_ONE_HOT: assert property ($onehot0(time_state))
    else $error("time state not one-hot");
  AST_IDLE_STAY: assert property (time_state == TS_IDLE && !start |=> time_state == TS_IDLE)
    else $error("left idle without start");
  AST_START: assert property (time_state == TS_IDLE && start |=> time_state == TS_TF1 && running)
    else $error("start did not enter fetch one");
  AST_TF1_NEXT: assert property (time_state[TF1] |=> time_state[TF1] || time_state == TS_TF2)
    else $error("fetch one not followed by fetch two");
  AST_DWELL: assert property (time_state != prev_r && prev_r != TS_IDLE && !prev_r[TE4]
    && time_state != TS_IDLE |-> dwell_r == 6'(STATE_CYC - 1))
    else $error("time state length wrong");
  AST_ADDR_PC: assert property ($rose(time_state[TF2]) && $past(time_state[TF1])
    |-> mem_addr == $past(view.pc))
    else $error("address not loaded from pc");
  AST_PC_INC: assert property ($rose(time_state[TF3]) && norm_r |-> view.pc == mem_addr + 13'h0001)
    else $error("pc not advanced in fetch two");
  AST_MEM_READ: assert property ($rose(time_state[TF3]) |-> mem_go && mem_read ##1 !mem_go)
    else $error("no read cycle started");
  AST_W_CLEAR: assert property ($rose(time_state[TF3]) |-> ##[0:2] view.wr == WORD_RST)
    else $error("working reg not cleared");
  AST_W_LOAD: assert property ($fell(time_state[TF3]) |-> view.wr == $past(mem_rdata))
    else $error("working reg not loaded from memory");
  AST_FUNC: assert property ($rose(time_state[TF5]) && norm_r |-> view.func == $past(view.wr[11:8]))
    else $error("function reg not loaded");
  AST_SECTOR: assert property ($rose(time_state[TE1]) && norm_r && !view.wr[11] && view.wr[10:8] != 3'h0
    && !view.wr[7] |-> mem_addr == {6'h00, view.wr[6:0]})
    else $error("primary sector address wrong");
  // ****************
  // covers
  // ****************
  COV_HALT: cover property ($fell(running));
  COV_INDIRECT: cover property (time_state[TF2] && prev_r[TF5]);
  COV_EXEC: cover property ($rose(time_state[TE4]));
endmodule : serial_cpu_datapath_fetch_chk

bind serial_cpu_datapath_fetch serial_cpu_datapath_fetch_chk u_chk (.clk(clk), .rst(rst), .start(start),
  .stop(stop), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_go(mem_go),
  .mem_read(mem_read), .time_state(time_state), .running(running), .view(view));

// File: tb_serial_cpu_datapath_fetch.sv
module tb_serial_cpu_datapath_fetch
  import cpu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, start, stop, mem_go, mem_read, running;
  logic [WORD_W-1:0] mem_rdata, mem_wdata;
  logic [ADDR_W-1:0] mem_addr;
  logic [TS_N-1:0] time_state;
  cpu_view_t view;
  int err_total, n_checks, n;
  logic [11:0] a_v, b_v, c_v, d_v, e_v, t_v;
  logic [12:0] sum_v;
  // lda, oca, add, sta, lda indirect, jmp, trap, halt; tca, ana, lgr 3, sta, irs, toa, jst
  logic [11:0] prog [0:14] = '{12'h140, 12'h003, 12'h441, 12'h242, 12'h943, 12'h307, 12'h140, 12'h000,
    12'h005, 12'h546, 12'h04C, 12'h247, 12'h648, 12'h018, 12'h750};

  always #5 clk = ~clk;

  serial_cpu_datapath_fetch DUT (.clk(clk), .rst(rst), .start(start), .stop(stop), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_go(mem_go), .mem_read(mem_read),
    .time_state(time_state), .running(running), .view(view));
  core_mem_model u_mem (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_go(mem_go),
    .mem_read(mem_read), .mem_rdata(mem_rdata));

  // ****************
  // helpers
  // ****************
  function automatic logic [12:0] exp_sum(input logic [11:0] x, input logic [11:0] y);
    return {1'b0, ~x} + {1'b0, y};
  endfunction : exp_sum

  // negate, and with y, logical right shift by three
  function automatic logic [11:0] exp_neg_and(input logic [11:0] x, input logic [11:0] y);
    return ((~x + 12'h001) & y) >> 3;
  endfunction : exp_neg_and

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_ts(input logic [TS_N-1:0] got, input logic [TS_N-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t time state got %h exp %h", $time, got, exp);
    end
  endtask : chk_ts

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic wait_ts(input logic [TS_N-1:0] ts, input int limit, output int cnt);
    cnt = 0;
    while (time_state !== ts && cnt < limit) begin
      step;
      cnt++;
    end
    if (cnt >= limit) begin
      err_total++;
      $display("[FAIL] %0t wait for time state %h ran out", $time, ts);
      close_out;
    end
  endtask : wait_ts

  task automatic pulse_start;
    step;
    start = 1'b1;
    step;
    start = 1'b0;
  endtask : pulse_start

  // ****************
  // main sequence
  // ****************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    stop = 1'b0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(95071));
    for (int it = 0; it < 3; it++) begin
      rst = 1'b1;
      step;
      step;
      rst = 1'b0;
      chk_ts(time_state, TS_IDLE);
      chk_val({12'h000, running}, 13'h0000, "run flag after reset");
      chk_val(view.pc, ADDR_RST, "pc after reset");
      a_v = (it == 0) ? 12'h000 : (it == 1) ? 12'hFFF : 12'($urandom);
      b_v = (it == 0) ? 12'h001 : (it == 1) ? 12'hFFF : 12'($urandom);
      c_v = 12'($urandom);
      d_v = 12'($urandom);
      e_v = (it == 1) ? 12'hFFF : 12'($urandom);
      for (int i = 0; i < 15; i++) begin
        u_mem.mem[i] = prog[i];
      end
      u_mem.mem[64] = a_v;
      u_mem.mem[65] = b_v;
      u_mem.mem[67] = 12'h044;
      u_mem.mem[68] = c_v;
      u_mem.mem[70] = d_v;
      u_mem.mem[72] = e_v;
      u_mem.mem[80] = 12'h000;
      u_mem.mem[81] = 12'h351;
      sum_v = exp_sum(a_v, b_v);
      t_v = exp_neg_and(c_v, d_v);
      pulse_start;
      chk_ts(time_state, TS_TF1);
      wait_ts(TS_TF2, 100, n);
      chk_val(13'(n), 13'(STATE_CYC), "fetch one length");
      chk_val(mem_addr, 13'h0000, "address from pc");
      wait_ts(11'h004, 100, n);
      chk_val(view.pc, 13'h0001, "pc advanced");
      wait_ts(11'h008, 100, n);
      chk_val({1'b0, view.wr}, 13'h0140, "instruction in working reg");
      wait_ts(11'h010, 100, n);
      chk_val({9'h000, view.func}, 13'h0001, "function reg");
      wait_ts(TS_IDLE, 20000, n);
      step;
      chk_val({1'b0, view.acc}, {1'b0, c_v}, "acc from indirect load");
      chk_val({1'b0, u_mem.mem[66]}, {1'b0, sum_v[11:0]}, "stored sum");
      chk_val({12'h000, view.carry}, {12'h000, sum_v[12]}, "carry kept");
      chk_val(view.pc, 13'h0008, "pc after jump and halt");
      chk_val({12'h000, running}, 13'h0000, "halted");
      chk_val({1'b0, u_mem.mem[0]}, 13'h0140, "instruction restored");
      pulse_start;
      repeat (4000) step;
      stop = 1'b1;
      wait_ts(TS_IDLE, 5000, n);
      step;
      stop = 1'b0;
      chk_val({12'h000, running}, 13'h0000, "stopped");
      chk_val(view.pc, 13'h0051, "pc in jump loop");
      chk_val({1'b0, u_mem.mem[71]}, {1'b0, t_v}, "negate, and, shift stored");
      chk_val({1'b0, u_mem.mem[72]}, {1'b0, e_v + 12'h001}, "incremented word");
      chk_val({1'b0, u_mem.mem[80]}, 13'h000F, "return address stored");
      chk_val({1'b0, view.acc}, (e_v == 12'hFFF) ? {1'b0, t_v} : 13'h0000, "overflow moved or skipped");
    end
    close_out;
  end
endmodule : tb_serial_cpu_datapath_fetch
